//--- src/blch_top.sv
// Bidirectional-mode transfer control with simultaneous-send handling
`timescale 1ns/1ps
// Overview of operation
// - Send invalid and collision: report code 3, do not await a reply.
// - Receive valid: after colliding reception, reply to host, hand data over.
// - Receive invalid and collision: drop data, no reply, nothing handed over.
// - Flow control on, both valid: DC3 or DSR low pauses send, DC1/DSR resumes.
// - A reply blocked by a send halt waits until DC1 or DSR high.
// - Program raises send request, module raises completion, program drops request.
// - Module raises read request, program raises read complete, module drops request.
// - Module ready and watchdog fault flags are presented to the program.
// - Buffer memory reloads defaults at power-on, CPU reset and mode switch.
// - On send request, send the configured count from the lowest send address.
module blch_top #(
  parameter int RESP_TIMEOUT_CYC = blch_pkg::RESP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Controller program side
  input wire logic cpu_reset,
  input wire logic mode_switch,
  input wire logic cpu_en,
  input wire logic cpu_we,
  input wire logic [11:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic send_request,
  input wire logic read_complete,
  output logic send_completed_flag,
  output logic rx_read_request_flag,
  output logic module_ready_flag,
  output logic watchdog_fault_flag,
  // Host link side
  input wire logic flow_ctrl_en,
  input wire logic dsr_pin,
  input wire logic host_dc1,
  input wire logic host_dc3,
  input wire logic host_ack,
  input wire logic host_nak,
  input wire logic rx_busy,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic rx_last,
  input wire logic rx_error,
  output logic [15:0] tx_data,
  output logic tx_is_resp,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready
);
  // ****************************************
  // Declarations
  // ****************************************
  blch_pkg::blch_state_t state;
  blch_mem_if #(.AW(blch_pkg::AW), .DW(blch_pkg::DW)) cpu_bus ();
  blch_mem_if #(.AW(blch_pkg::AW), .DW(blch_pkg::DW)) eng_bus ();
  logic init_busy;
  logic [11:0] init_addr;
  logic [15:0] policy;
  logic send_inv;
  logic recv_inv;
  logic dsr_s1, dsr_s2, dsr_s3, dsr_level;
  logic dc3_seen;
  logic halted;
  logic tx_busy;
  logic tx_collide;
  logic [11:0] send_len;
  logic [11:0] word_idx;
  logic [31:0] resp_cnt;
  logic [15:0] res_code;
  logic [11:0] rx_cnt;
  logic [11:0] rx_len_q;
  logic rx_collide;
  logic rx_err;
  logic [1:0] rx_fin;
  logic rx_end;
  logic rx_drop;
  logic resp_pend;
  logic resp_nak;
  logic resp_push;
  logic data_push;
  logic buf_in_ready;
  logic [17:0] buf_in_data;
  logic [17:0] buf_out_data;
  logic free1, free2, g_fin, g_res, g_rd;

  function automatic logic is_sending(input blch_pkg::blch_state_t s);
    is_sending = (s == blch_pkg::ST_LEN_RD) || (s == blch_pkg::ST_LEN_WT) ||
                 (s == blch_pkg::ST_DATA_RD) || (s == blch_pkg::ST_DATA_PUSH);
  endfunction : is_sending

  // ****************************************
  // Policy decode and buffer memory
  // ****************************************
  assign send_inv = policy[blch_pkg::POL_SEND_INV_BIT];
  assign recv_inv = policy[blch_pkg::POL_RECV_INV_BIT];
  assign cpu_bus.en = cpu_en;
  assign cpu_bus.we = cpu_we && !init_busy;
  assign cpu_bus.addr = cpu_addr;
  assign cpu_bus.wdata = cpu_wdata;
  assign cpu_rdata = cpu_bus.rdata;

  blch_mem #(.DEPTH(blch_pkg::MEM_DEPTH)) u_mem (
    .clk_sys(clk_sys),
    .port_a(cpu_bus),
    .port_b(eng_bus)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      policy <= blch_pkg::POLICY_RESET;
    else if (init_busy)
      policy <= blch_pkg::POLICY_RESET;
    else if (cpu_en && cpu_we && (cpu_addr == blch_pkg::POLICY_ADDR))
      policy <= cpu_wdata;
  end

  // Default reload sweep
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      init_busy <= 1'b1;
      init_addr <= 12'h000;
    end
    else if (cpu_reset || mode_switch)
    begin
      init_busy <= 1'b1;
      init_addr <= 12'h000;
    end
    else if (init_busy)
    begin
      init_addr <= init_addr + 12'h001;
      if (int'(init_addr) == blch_pkg::MEM_DEPTH - 1)
        init_busy <= 1'b0;
    end
  end

  // Engine port arbitration
  assign free1 = !init_busy && !rx_word_valid;
  assign free2 = free1 && (rx_fin == 2'h0);
  assign g_fin = free1 && (rx_fin != 2'h0);
  assign g_res = free2 && (state == blch_pkg::ST_RESULT);
  assign g_rd = free2 && ((state == blch_pkg::ST_LEN_RD) || (state == blch_pkg::ST_DATA_RD));

  always_comb
  begin
    eng_bus.en = 1'b0;
    eng_bus.we = 1'b0;
    eng_bus.addr = 12'h000;
    eng_bus.wdata = blch_pkg::MEM_DEFAULT;
    if (init_busy)
    begin
      eng_bus.en = 1'b1;
      eng_bus.we = 1'b1;
      eng_bus.addr = init_addr;
    end
    else if (rx_word_valid)
    begin
      eng_bus.en = rx_cnt < blch_pkg::RX_MAX;
      eng_bus.we = 1'b1;
      eng_bus.addr = blch_pkg::RX_DATA + rx_cnt;
      eng_bus.wdata = rx_word;
    end
    else if (g_fin)
    begin
      eng_bus.en = 1'b1;
      eng_bus.we = 1'b1;
      eng_bus.addr = (rx_fin == 2'h1) ? blch_pkg::RX_BASE : blch_pkg::RX_RES_ADDR;
      eng_bus.wdata = (rx_fin == 2'h1) ? {4'h0, rx_len_q} : blch_pkg::RES_OK;
    end
    else if (g_res)
    begin
      eng_bus.en = 1'b1;
      eng_bus.we = 1'b1;
      eng_bus.addr = blch_pkg::SEND_RES_ADDR;
      eng_bus.wdata = res_code;
    end
    else if (g_rd)
    begin
      eng_bus.en = 1'b1;
      eng_bus.addr = (state == blch_pkg::ST_LEN_RD) ? blch_pkg::SEND_BASE : blch_pkg::SEND_DATA + word_idx;
    end
  end

  // ****************************************
  // Flow control
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dsr_s1 <= 1'b1;
      dsr_s2 <= 1'b1;
      dsr_s3 <= 1'b1;
      dsr_level <= 1'b1;
    end
    else
    begin
      dsr_s1 <= dsr_pin;
      dsr_s2 <= dsr_s1;
      dsr_s3 <= dsr_s2;
      if (dsr_s2 == dsr_s3)
        dsr_level <= dsr_s3;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      dc3_seen <= 1'b0;
    else if (host_dc3)
      dc3_seen <= 1'b1;
    else if (host_dc1)
      dc3_seen <= 1'b0;
  end

  assign halted = flow_ctrl_en && !send_inv && !recv_inv && (dc3_seen || !dsr_level);

  // ****************************************
  // Send sequencer
  // ****************************************
  assign tx_busy = is_sending(state);
  assign data_push = (state == blch_pkg::ST_DATA_PUSH) && !halted && buf_in_ready && !init_busy;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= blch_pkg::ST_IDLE;
      send_len <= 12'h000;
      word_idx <= 12'h000;
      resp_cnt <= 32'h0000_0000;
      res_code <= blch_pkg::RES_OK;
    end
    else if (init_busy)
      state <= blch_pkg::ST_IDLE;
    else
    begin
      case (state)
        blch_pkg::ST_IDLE:
          if (send_request && !send_completed_flag)
            state <= blch_pkg::ST_LEN_RD;
        blch_pkg::ST_LEN_RD:
          if (g_rd)
            state <= blch_pkg::ST_LEN_WT;
        blch_pkg::ST_LEN_WT:
        begin
          send_len <= eng_bus.rdata[11:0];
          word_idx <= 12'h000;
          res_code <= blch_pkg::RES_OK;
          state <= (eng_bus.rdata[11:0] == 12'h000) ? blch_pkg::ST_RESULT : blch_pkg::ST_DATA_RD;
        end
        blch_pkg::ST_DATA_RD:
          if (g_rd)
            state <= blch_pkg::ST_DATA_PUSH;
        blch_pkg::ST_DATA_PUSH:
          if (data_push)
          begin
            word_idx <= word_idx + 12'h001;
            resp_cnt <= 32'h0000_0000;
            if (word_idx + 12'h001 != send_len)
              state <= blch_pkg::ST_DATA_RD;
            else if (send_inv && (tx_collide || rx_busy))
            begin
              res_code <= blch_pkg::RES_COLLIDE;
              state <= blch_pkg::ST_RESULT;
            end
            else
              state <= blch_pkg::ST_RESP_WAIT;
          end
        blch_pkg::ST_RESP_WAIT:
          if (host_ack)
            state <= blch_pkg::ST_RESULT;
          else if (host_nak)
          begin
            res_code <= blch_pkg::RES_NAK;
            state <= blch_pkg::ST_RESULT;
          end
          else if (resp_cnt == 32'(RESP_TIMEOUT_CYC - 1))
          begin
            res_code <= blch_pkg::RES_TIMEOUT;
            state <= blch_pkg::ST_RESULT;
          end
          else
            resp_cnt <= resp_cnt + 32'h0000_0001;
        blch_pkg::ST_RESULT:
          if (g_res)
            state <= blch_pkg::ST_DONE;
        blch_pkg::ST_DONE:
          if (!send_request)
            state <= blch_pkg::ST_IDLE;
        default:
          state <= blch_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tx_collide <= 1'b0;
    else if (state == blch_pkg::ST_IDLE)
      tx_collide <= 1'b0;
    else if (tx_busy && rx_busy)
      tx_collide <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      send_completed_flag <= 1'b0;
    else if (init_busy || (state == blch_pkg::ST_DONE && !send_request))
      send_completed_flag <= 1'b0;
    else if (g_res)
      send_completed_flag <= 1'b1;
  end

  // ****************************************
  // Receive handling
  // ****************************************
  assign rx_end = !init_busy && rx_word_valid && rx_last;
  assign rx_drop = recv_inv && (rx_collide || tx_busy);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_cnt <= 12'h000;
      rx_len_q <= 12'h000;
      rx_collide <= 1'b0;
      rx_err <= 1'b0;
      rx_fin <= 2'h0;
    end
    else if (init_busy)
    begin
      rx_cnt <= 12'h000;
      rx_collide <= 1'b0;
      rx_err <= 1'b0;
      rx_fin <= 2'h0;
    end
    else
    begin
      if (rx_end)
      begin
        rx_cnt <= 12'h000;
        rx_collide <= 1'b0;
        rx_err <= 1'b0;
        rx_len_q <= (rx_cnt < blch_pkg::RX_MAX) ? rx_cnt + 12'h001 : rx_cnt;
        if (!rx_drop && !rx_err && !rx_error)
          rx_fin <= 2'h1;
      end
      else
      begin
        if (rx_word_valid && (rx_cnt < blch_pkg::RX_MAX))
          rx_cnt <= rx_cnt + 12'h001;
        if (rx_word_valid && rx_error)
          rx_err <= 1'b1;
        if (tx_busy && (rx_busy || rx_word_valid))
          rx_collide <= 1'b1;
        else if (!rx_busy && !rx_word_valid)
          rx_collide <= 1'b0;
      end
      if (g_fin)
        rx_fin <= (rx_fin == 2'h1) ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rx_read_request_flag <= 1'b0;
    else if (init_busy)
      rx_read_request_flag <= 1'b0;
    else if (g_fin && rx_fin == 2'h2)
      rx_read_request_flag <= 1'b1;
    else if (read_complete)
      rx_read_request_flag <= 1'b0;
  end

  // Response to the host, held while a send halt stands
  assign resp_push = resp_pend && !halted && !tx_busy && buf_in_ready && !init_busy;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_pend <= 1'b0;
      resp_nak <= 1'b0;
    end
    else if (init_busy)
      resp_pend <= 1'b0;
    else if (rx_end && !rx_drop)
    begin
      resp_pend <= 1'b1;
      resp_nak <= rx_err || rx_error;
    end
    else if (resp_push)
      resp_pend <= 1'b0;
  end

  // ****************************************
  // Transmit buffer and status flags
  // ****************************************
  assign buf_in_data = resp_push ? {1'b1, 1'b1, (resp_nak ? blch_pkg::RESP_NAK : blch_pkg::RESP_ACK)} :
                       {1'b0, (word_idx + 12'h001 == send_len), eng_bus.rdata};

  blch_buf2 #(.WIDTH(18)) u_txbuf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(data_push || resp_push),
    .in_data(buf_in_data),
    .in_ready(buf_in_ready),
    .out_valid(tx_valid),
    .out_data(buf_out_data),
    .out_ready(tx_ready)
  );

  assign tx_is_resp = buf_out_data[17];
  assign tx_last = buf_out_data[16];
  assign tx_data = buf_out_data[15:0];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      module_ready_flag <= 1'b0;
    else
      module_ready_flag <= !init_busy && !cpu_reset && !mode_switch;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      watchdog_fault_flag <= 1'b0;
    else if (state == blch_pkg::ST_RESP_WAIT && resp_cnt > 32'(RESP_TIMEOUT_CYC - 1))
      watchdog_fault_flag <= 1'b1;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_last_push;
    data_push && (word_idx + 12'h001 == send_len);
  endsequence

  a_collide_no_wait: assert property (s_last_push and (send_inv && tx_collide) |=>
    state == blch_pkg::ST_RESULT && res_code == blch_pkg::RES_COLLIDE) else $error("collision code not reported");
  a_send_waits_reply: assert property (s_last_push and !send_inv |=>
    state == blch_pkg::ST_RESP_WAIT) else $error("valid send did not await reply");
  a_reply_timeout: assert property (state == blch_pkg::ST_RESP_WAIT && !host_ack && !host_nak &&
    resp_cnt == 32'(RESP_TIMEOUT_CYC - 1) |=> res_code == blch_pkg::RES_TIMEOUT) else $error("time-out missed");
  a_rx_dropped: assert property (rx_end && rx_drop |=> !resp_pend [*2]) else $error("dropped reception answered");
  a_rx_handover: assert property (rx_end && !rx_drop && !rx_err && !rx_error |->
    ##[1:8] $rose(rx_read_request_flag)) else $error("reception not handed over");
  a_halt_blocks: assert property (halted && !init_busy && state == blch_pkg::ST_DATA_PUSH |=>
    state == blch_pkg::ST_DATA_PUSH && $stable(word_idx)) else $error("send advanced during halt");
  a_reply_held: assert property (halted && resp_pend && !init_busy |=> resp_pend)
    else $error("reply sent during halt");
  a_done_release: assert property (state == blch_pkg::ST_DONE && !send_request |=>
    !send_completed_flag && state == blch_pkg::ST_IDLE) else $error("completion not released");
  a_rdreq_release: assert property (rx_read_request_flag && read_complete && !(g_fin && rx_fin == 2'h2) |=>
    !rx_read_request_flag) else $error("read request not lowered");
  a_reload_ready: assert property ($rose(init_busy) |-> !module_ready_flag ##1
    (policy == blch_pkg::POLICY_RESET && !module_ready_flag)) else $error("reload not applied");
  a_first_addr: assert property (state == blch_pkg::ST_DATA_RD && word_idx == 12'h000 && g_rd |->
    eng_bus.addr == blch_pkg::SEND_DATA) else $error("send not from lowest address");
endmodule : blch_top

//--- src/blch_pkg.sv
// Shared constants, layouts and states of the bidirectional link collision handler
package blch_pkg;
  // ****************************************
  // Buffer memory geometry
  // ****************************************
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int MEM_DEPTH = 3584;
  localparam logic [15:0] MEM_DEFAULT = 16'h0000;
  // ****************************************
  // Buffer memory layout
  // ****************************************
  localparam logic [11:0] SEND_BASE = 12'h000;
  localparam logic [11:0] SEND_DATA = 12'h001;
  localparam logic [11:0] RX_BASE = 12'h080;
  localparam logic [11:0] RX_DATA = 12'h081;
  localparam logic [11:0] RX_MAX = 12'h07f;
  localparam logic [11:0] POLICY_ADDR = 12'h114;
  localparam logic [11:0] RX_RES_ADDR = 12'h115;
  localparam logic [11:0] SEND_RES_ADDR = 12'h116;
  localparam logic [15:0] POLICY_RESET = 16'h0000;
  localparam int POL_SEND_INV_BIT = 8;
  localparam int POL_RECV_INV_BIT = 0;
  // ****************************************
  // Result and response codes
  // ****************************************
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_COLLIDE = 16'h0003;
  localparam logic [15:0] RES_NAK = 16'h0010;
  localparam logic [15:0] RES_TIMEOUT = 16'h0011;
  localparam logic [15:0] RESP_ACK = 16'h0006;
  localparam logic [15:0] RESP_NAK = 16'h0015;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50000000;
  localparam int RESP_TIMEOUT_MS = 100;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * (CLK_HZ / 1000);
  // ****************************************
  // Send sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEN_RD = 3'h1,
    ST_LEN_WT = 3'h3,
    ST_DATA_RD = 3'h2,
    ST_DATA_PUSH = 3'h6,
    ST_RESP_WAIT = 3'h7,
    ST_RESULT = 3'h5,
    ST_DONE = 3'h4
  } blch_state_t;
endpackage : blch_pkg

//--- src/blch_mem_if.sv
// Buffer memory access port bundle
`timescale 1ns/1ps
interface blch_mem_if #(
  parameter int AW = 12,
  parameter int DW = 16
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport master (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : blch_mem_if

//--- src/blch_mem.sv
// Two-port buffer memory with registered read data
`timescale 1ns/1ps
module blch_mem #(
  parameter int DEPTH = blch_pkg::MEM_DEPTH
) (
  // Clock
  input wire logic clk_sys,
  // Access ports
  blch_mem_if.mem port_a,
  blch_mem_if.mem port_b
);
  logic [15:0] store [DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (port_a.en && port_a.we && (int'(port_a.addr) < DEPTH))
      store[port_a.addr] <= port_a.wdata;
    if (port_b.en && port_b.we && (int'(port_b.addr) < DEPTH))
      store[port_b.addr] <= port_b.wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (port_a.en && !port_a.we)
      port_a.rdata <= (int'(port_a.addr) < DEPTH) ? store[port_a.addr] : 16'h0000;
  end

  always_ff @(posedge clk_sys)
  begin
    if (port_b.en && !port_b.we)
      port_b.rdata <= (int'(port_b.addr) < DEPTH) ? store[port_b.addr] : 16'h0000;
  end
endmodule : blch_mem

//--- src/blch_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module blch_buf2 #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] spare;
  logic spare_valid;
  logic pop;
  logic push;

  assign in_ready = !spare_valid;
  assign pop = out_valid && out_ready;
  assign push = in_valid && in_ready;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop || !out_valid)
    begin
      out_valid <= spare_valid || push;
      out_data <= spare_valid ? spare : in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      spare_valid <= 1'b0;
      spare <= '0;
    end
    else if (spare_valid && pop)
      spare_valid <= 1'b0;
    else if (push && out_valid && !pop)
    begin
      spare_valid <= 1'b1;
      spare <= in_data;
    end
  end
endmodule : blch_buf2

//--- sim/blch_host_model.sv
// Host computer on the far side of the link
`timescale 1ns/1ps
module blch_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Words from the block
  input wire logic [15:0] tx_data,
  input wire logic tx_is_resp,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Replies to a send
  output logic host_ack,
  output logic host_nak,
  // Reply choice: 0 ack, 1 nak, 2 silent
  input wire logic [1:0] rmode
);
  // ****************************************
  // Word capture and reply
  // ****************************************
  logic [16:0] q[$];
  logic [1:0] cnt;
  logic [2:0] dly;
  // Stall one cycle in four
  assign tx_ready = cnt != 2'h3;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 2'h0;
      dly <= 3'h0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      dly <= (dly != 3'h0) ? dly - 3'h1 : 3'h0;
      if (tx_valid && tx_ready)
      begin
        q.push_back({tx_is_resp, tx_data});
        if (tx_last && !tx_is_resp)
          dly <= 3'h3;
      end
    end
  end
  assign host_ack = dly == 3'h1 && rmode == 2'h0;
  assign host_nak = dly == 3'h1 && rmode == 2'h1;
endmodule : blch_host_model

//--- sim/blch_top_tb_top.sv
// Self-checking bench of the collision handler
`timescale 1ns/1ps
module blch_top_tb_top;
  logic clk_sys, resetn, cpu_reset, mode_switch, cpu_en, cpu_we, send_request, read_complete;
  logic flow_ctrl_en, dsr_pin, host_dc1, host_dc3, rx_busy, rx_word_valid, rx_last, rx_error;
  logic send_completed_flag, rx_read_request_flag, module_ready_flag, watchdog_fault_flag;
  logic tx_is_resp, tx_last, tx_valid, tx_ready, host_ack, host_nak;
  logic [11:0] cpu_addr;
  logic [15:0] cpu_wdata, rx_word, cpu_rdata, tx_data;
  logic [15:0] sd[4], rw[4];
  logic [1:0] rmode;
  int n_fail, compares;
  blch_top #(.RESP_TIMEOUT_CYC(50)) i_dut (.*);
  blch_host_model i_host (.*);
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'h1; k++)
      @(negedge clk_sys);
    if (s !== 1'h1)
    begin
      n_fail++;
      close_out();
    end
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(negedge clk_sys);
    {cpu_en, cpu_we, cpu_addr, cpu_wdata} = {2'h3, a, v};
    @(negedge clk_sys);
    cpu_en = 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    {cpu_en, cpu_we, cpu_addr} = {2'h2, a};
    @(negedge clk_sys);
    cpu_en = 1'h0;
    @(negedge clk_sys);
    chk(cpu_rdata, e);
  endtask : rd
  function automatic logic [15:0] exp_res(input logic [1:0] m, input logic [15:0] p, input logic c);
    if (c && p[8])
      return blch_pkg::RES_COLLIDE;
    return m == 2'h0 ? blch_pkg::RES_OK : (m == 2'h1 ? blch_pkg::RES_NAK : blch_pkg::RES_TIMEOUT);
  endfunction : exp_res
  task automatic snd(input int n, input logic [15:0] res);
    i_host.q.delete();
    wr(blch_pkg::SEND_BASE, 16'(n));
    for (int k = 0; k < n; k++)
    begin
      sd[k] = 16'($urandom);
      wr(blch_pkg::SEND_DATA + 12'(k), sd[k]);
    end
    @(negedge clk_sys);
    send_request = 1'h1;
    wt(send_completed_flag, 600);
    rd(blch_pkg::SEND_RES_ADDR, res);
    chk(16'(i_host.q.size()), 16'(n));
    for (int k = 0; k < n; k++)
    begin
      chk(i_host.q[k][15:0], sd[k]);
      chk({15'h0, i_host.q[k][16]}, 16'h0);
    end
    send_request = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk({15'h0, send_completed_flag}, 16'h0);
  endtask : snd
  task automatic rxm(input int n, input int e);
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk_sys);
      rw[k] = 16'($urandom);
      {rx_busy, rx_word_valid, rx_last, rx_error, rx_word} = {2'h3, k == n - 1, k == e, rw[k]};
      @(negedge clk_sys);
      {rx_word_valid, rx_error} = 2'h0;
    end
    rx_busy = 1'h0;
  endtask : rxm
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    {resetn, cpu_reset, mode_switch, cpu_en, cpu_we, send_request, read_complete} = 7'h0;
    {flow_ctrl_en, host_dc1, host_dc3, rx_busy, rx_word_valid, rx_last, rx_error} = 7'h0;
    {cpu_addr, cpu_wdata, rx_word, rmode} = 46'h0;
    dsr_pin = 1'h1;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'hf365));
    repeat (8) @(negedge clk_sys);
    resetn = 1'h1;
    wt(module_ready_flag, 4000);
    rd(blch_pkg::POLICY_ADDR, blch_pkg::POLICY_RESET);
    chk({12'h0, send_completed_flag, rx_read_request_flag, module_ready_flag, watchdog_fault_flag}, 16'h2);
    for (int i = 0; i < 4; i++)
    begin
      rmode = 2'(i % 3);
      snd(3 - i, exp_res(rmode, 16'h0, 1'h0));
    end
    rmode = 2'h0;
    flow_ctrl_en = 1'h1;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_sys);
      host_dc3 = i == 0;
      dsr_pin = i == 0;
      @(negedge clk_sys);
      host_dc3 = 1'h0;
      fork
        snd(2, blch_pkg::RES_OK);
        begin
          repeat (40) @(negedge clk_sys);
          chk(16'(i_host.q.size()), 16'h0);
          {host_dc1, dsr_pin} = 2'h3;
          @(negedge clk_sys);
          host_dc1 = 1'h0;
        end
      join
    end
    i_host.q.delete();
    host_dc3 = 1'h1;
    @(negedge clk_sys);
    host_dc3 = 1'h0;
    rxm(3, 3);
    wt(rx_read_request_flag, 100);
    chk(16'(i_host.q.size()), 16'h0);
    host_dc1 = 1'h1;
    @(negedge clk_sys);
    {host_dc1, flow_ctrl_en} = 2'h0;
    rd(blch_pkg::RX_BASE, 16'h3);
    for (int k = 0; k < 3; k++)
      rd(blch_pkg::RX_DATA + 12'(k), rw[k]);
    rd(blch_pkg::RX_RES_ADDR, blch_pkg::RES_OK);
    chk(i_host.q[0][15:0], blch_pkg::RESP_ACK);
    chk({15'h0, i_host.q[0][16]}, 16'h1);
    read_complete = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk({15'h0, rx_read_request_flag}, 16'h0);
    read_complete = 1'h0;
    i_host.q.delete();
    rxm(2, 0);
    repeat (10) @(negedge clk_sys);
    chk({15'h0, rx_read_request_flag}, 16'h0);
    chk(i_host.q[0][15:0], blch_pkg::RESP_NAK);
    wr(blch_pkg::POLICY_ADDR, 16'h0100);
    rmode = 2'h2;
    rx_busy = 1'h1;
    snd(2, exp_res(rmode, 16'h0100, 1'h1));
    rx_busy = 1'h0;
    wr(blch_pkg::POLICY_ADDR, 16'h0001);
    fork
      snd(1, exp_res(rmode, 16'h0001, 1'h1));
      begin
        repeat (8) @(negedge clk_sys);
        rxm(3, 3);
      end
    join
    chk({15'h0, rx_read_request_flag}, 16'h0);
    chk({15'h0, watchdog_fault_flag}, 16'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(blch_pkg::POLICY_ADDR, 16'h0101);
      @(negedge clk_sys);
      {cpu_reset, mode_switch} = i == 0 ? 2'h2 : 2'h1;
      @(negedge clk_sys);
      {cpu_reset, mode_switch} = 2'h0;
      wt(module_ready_flag, 4000);
      rd(blch_pkg::POLICY_ADDR, blch_pkg::POLICY_RESET);
    end
    close_out();
  end
endmodule : blch_top_tb_top
